// ==== pss_pkg.sv ====
package pss_pkg;
    // register indexes; byte address is four times the index
    localparam logic [5:0] IDX_STATUS   = 6'h10;
    localparam logic [5:0] IDX_CONTROL  = 6'h11;
    localparam logic [5:0] IDX_IRQ_STS  = 6'h18;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h19;

    // reset values
    localparam logic [15:0] STATUS_RST  = 16'h0002;
    localparam logic [15:0] CONTROL_RST = 16'h0108;
    localparam logic [3:0]  IRQ_RST     = 4'h0;
    // control bits that software may hold (reserved ones read zero)
    localparam logic [15:0] CONTROL_WMASK = 16'hFB1F;

    // summary word field positions
    localparam int B_SWAP   = 14;
    localparam int B_RXERR  = 13;
    localparam int B_POL    = 12;
    localparam int B_FCAR   = 11;
    localparam int B_SIGDET = 10;
    localparam int B_DLOCK  = 9;
    localparam int B_PAGE   = 8;
    localparam int B_IPEND  = 7;
    localparam int B_RFAULT = 6;
    localparam int B_JAB    = 5;
    localparam int B_ANDONE = 4;
    localparam int B_LOOP   = 3;
    localparam int B_DUPLEX = 2;
    localparam int B_SPEED  = 1;
    localparam int B_LINK   = 0;

    // interrupt status bit positions
    localparam int I_RXERR  = 0;
    localparam int I_FCAR   = 1;
    localparam int I_RFAULT = 2;
    localparam int I_LINK   = 3;
endpackage : pss_pkg

// ==== pss_status_regs.sv ====
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
module pss_status_regs (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone classic slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // status sources, same clock
    input  wire logic        pair_swap_i,
    input  wire logic        rx_err_ev_i,
    input  wire logic        rx_err_cnt_rd_i,
    input  wire logic        polarity_inv_i,
    input  wire logic        false_car_ev_i,
    input  wire logic        false_car_cnt_rd_i,
    input  wire logic        signal_detect_i,
    input  wire logic        descr_lock_i,
    input  wire logic        page_rcvd_i,
    input  wire logic        int_pending_i,
    input  wire logic        int_status_rd_i,
    input  wire logic        remote_fault_ev_i,
    input  wire logic        base_status_rd_i,
    input  wire logic        jabber_i,
    input  wire logic        an_enable_i,
    input  wire logic        an_complete_i,
    input  wire logic        an_full_duplex_i,
    input  wire logic        an_speed_10_i,
    input  wire logic        mii_loopback_i,
    input  wire logic        link_i,
    // pins: strap levels and pin mode
    input  wire logic        strap_duplex_i,
    input  wire logic        strap_speed_10_i,
    input  wire logic        ext_mode_i,
    output logic             irq_o
);

    ////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [1:0]  dup_sync;
        logic [1:0]  spd_sync;
        logic [1:0]  ext_sync;
        logic [1:0]  sync_fill;
        logic        strap_taken;
        logic        strap_dup;
        logic        strap_spd;
        logic        strap_ext;
        logic        rxerr;
        logic        fcar;
        logic        ipend;
        logic        rfault;
        logic        link_prev;
        logic [15:0] status;
        logic [15:0] control;
        logic [3:0]  irq_sts;
        logic [3:0]  irq_mask;
        logic        ack;
        logic [31:0] rdata;
    } pss_state_type;

    pss_state_type s_q;
    pss_state_type s_d;

    logic       req;
    logic [5:0] idx;
    logic [3:0] irq_ev;
    logic       duplex_v;
    logic       speed_v;

    // merge byte lanes of a write into a 16-bit register
    function automatic logic [15:0] pss_merge(input logic [15:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = wd[7:0];
        end
        if (sel[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // next state

    // one request per ack; the gap cycle keeps one read from clearing twice
    assign req = cyc_i && stb_i && !s_q.ack;
    assign idx = adr_i[7:2];

    always_comb begin
        s_d = s_q;
        irq_ev = 4'h0;
        duplex_v = 1'b0;
        speed_v = 1'b1;

        // pins pass two flops; the first stage feeds only the second
        s_d.dup_sync = {s_q.dup_sync[0], strap_duplex_i};
        s_d.spd_sync = {s_q.spd_sync[0], strap_speed_10_i};
        s_d.ext_sync = {s_q.ext_sync[0], ext_mode_i};
        // straps are caught once after reset, when the sync chain is full;
        // catching at once would take the zeros that reset left in it
        s_d.sync_fill = {s_q.sync_fill[0], 1'b1};
        if (!s_q.strap_taken && s_q.sync_fill[1]) begin
            s_d.strap_taken = 1'b1;
            s_d.strap_dup = s_q.dup_sync[1];
            s_d.strap_spd = s_q.spd_sync[1];
            s_d.strap_ext = s_q.ext_sync[1];
        end

        // latched bits: a new event wins over the clearing read
        if (rx_err_ev_i) begin
            s_d.rxerr = 1'b1;
        end else if (rx_err_cnt_rd_i) begin
            s_d.rxerr = 1'b0;
        end
        if (false_car_ev_i) begin
            s_d.fcar = 1'b1;
        end else if (false_car_cnt_rd_i) begin
            s_d.fcar = 1'b0;
        end
        if (int_pending_i) begin
            s_d.ipend = 1'b1;
        end else if (int_status_rd_i) begin
            s_d.ipend = 1'b0;
        end
        if (remote_fault_ev_i) begin
            s_d.rfault = 1'b1;
        end else if (base_status_rd_i) begin
            s_d.rfault = 1'b0;
        end

        // forced-speed fallback until the strap is caught keeps reset value
        if (an_enable_i) begin
            duplex_v = an_full_duplex_i;
            speed_v = an_speed_10_i;
        end else if (s_q.strap_ext) begin
            duplex_v = 1'b1;
            speed_v = 1'b1;
        end else if (s_q.strap_taken) begin
            duplex_v = s_q.strap_dup;
            speed_v = s_q.strap_spd;
        end

        // summary word, rebuilt every cycle
        s_d.status = 16'h0000;
        s_d.status[pss_pkg::B_SWAP] = pair_swap_i;
        s_d.status[pss_pkg::B_RXERR] = s_q.rxerr;
        s_d.status[pss_pkg::B_POL] = polarity_inv_i;
        s_d.status[pss_pkg::B_FCAR] = s_q.fcar;
        s_d.status[pss_pkg::B_SIGDET] = signal_detect_i;
        s_d.status[pss_pkg::B_DLOCK] = descr_lock_i;
        s_d.status[pss_pkg::B_PAGE] = page_rcvd_i;
        s_d.status[pss_pkg::B_IPEND] = s_q.ipend;
        s_d.status[pss_pkg::B_RFAULT] = s_q.rfault;
        s_d.status[pss_pkg::B_JAB] = jabber_i;
        s_d.status[pss_pkg::B_ANDONE] = an_complete_i;
        s_d.status[pss_pkg::B_LOOP] = mii_loopback_i;
        s_d.status[pss_pkg::B_DUPLEX] = duplex_v;
        s_d.status[pss_pkg::B_SPEED] = speed_v;
        s_d.status[pss_pkg::B_LINK] = link_i;

        // interrupt events
        irq_ev[pss_pkg::I_RXERR] = rx_err_ev_i;
        irq_ev[pss_pkg::I_FCAR] = false_car_ev_i;
        irq_ev[pss_pkg::I_RFAULT] = remote_fault_ev_i;
        irq_ev[pss_pkg::I_LINK] = link_i ^ s_q.link_prev;
        s_d.link_prev = link_i;

        // bus: answer one cycle after the request, unmapped reads zero
        s_d.ack = req;
        s_d.rdata = 32'h0000_0000;
        if (req && !we_i) begin
            case (idx)
                pss_pkg::IDX_STATUS: begin
                    s_d.rdata = {16'h0000, s_q.status};
                end
                pss_pkg::IDX_CONTROL: begin
                    s_d.rdata = {16'h0000, s_q.control};
                end
                pss_pkg::IDX_IRQ_STS: begin
                    s_d.rdata = {28'h0000000, s_q.irq_sts};
                end
                pss_pkg::IDX_IRQ_MASK: begin
                    s_d.rdata = {28'h0000000, s_q.irq_mask};
                end
                default: begin
                    s_d.rdata = 32'h0000_0000;
                end
            endcase
        end
        // summary word has no write path at all
        if (req && we_i) begin
            case (idx)
                pss_pkg::IDX_CONTROL: begin
                    s_d.control = pss_merge(s_q.control, dat_i, sel_i)
                                  & pss_pkg::CONTROL_WMASK;
                end
                pss_pkg::IDX_IRQ_MASK: begin
                    if (sel_i[0]) begin
                        s_d.irq_mask = dat_i[3:0];
                    end
                end
                default: begin
                    s_d.control = s_q.control;
                end
            endcase
        end

        // status read clears, but an event in that cycle survives
        if (req && !we_i && idx == pss_pkg::IDX_IRQ_STS) begin
            s_d.irq_sts = irq_ev;
        end else begin
            s_d.irq_sts = s_q.irq_sts | irq_ev;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.status <= pss_pkg::STATUS_RST;
            s_q.control <= pss_pkg::CONTROL_RST;
            s_q.irq_sts <= pss_pkg::IRQ_RST;
            s_q.irq_mask <= pss_pkg::IRQ_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs
    assign dat_o = s_q.rdata;
    assign ack_o = s_q.ack;
    assign irq_o = |(s_q.irq_sts & s_q.irq_mask);

    ////////////////////////////////////////////////////////////////////
    // checks

    property p_rxerr_set;
        @(posedge clk_i) disable iff (rst_i)
        rx_err_ev_i |=> ##1 s_q.status[13];
    endproperty
    a_rxerr_set: assert property (p_rxerr_set)
        else $error("receive error latch not set");

    property p_rxerr_clr;
        @(posedge clk_i) disable iff (rst_i)
        rx_err_cnt_rd_i && !rx_err_ev_i |=> !s_q.rxerr ##1 !s_q.status[13];
    endproperty
    a_rxerr_clr: assert property (p_rxerr_clr)
        else $error("receive error latch not cleared");

    property p_fcar_hold;
        @(posedge clk_i) disable iff (rst_i)
        s_q.fcar && !false_car_cnt_rd_i |=> s_q.fcar;
    endproperty
    a_fcar_hold: assert property (p_fcar_hold)
        else $error("false carrier latch dropped");

    property p_rfault;
        @(posedge clk_i) disable iff (rst_i)
        remote_fault_ev_i ##1 !base_status_rd_i |=> s_q.status[6];
    endproperty
    a_rfault: assert property (p_rfault)
        else $error("remote fault not reported");

    property p_ipend_clr;
        @(posedge clk_i) disable iff (rst_i)
        int_status_rd_i && !int_pending_i |=> !s_q.ipend;
    endproperty
    a_ipend_clr: assert property (p_ipend_clr)
        else $error("pending bit not cleared");

    property p_link_mirror;
        @(posedge clk_i) disable iff (rst_i)
        ##1 s_q.status[0] == $past(link_i);
    endproperty
    a_link_mirror: assert property (p_link_mirror)
        else $error("link bit not mirrored");

    property p_bit15;
        @(posedge clk_i) disable iff (rst_i)
        ack_o |-> dat_o[15] == 1'b0 || $past(idx) != pss_pkg::IDX_STATUS;
    endproperty
    a_bit15: assert property (p_bit15)
        else $error("reserved bit reads one");

    property p_ext_duplex;
        @(posedge clk_i) disable iff (rst_i)
        !an_enable_i && s_q.strap_ext |=> s_q.status[2] && s_q.status[1];
    endproperty
    a_ext_duplex: assert property (p_ext_duplex)
        else $error("forced mode not full duplex 10");

    property p_ack_once;
        @(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("ack held two cycles");

    property p_fcar_set;
        @(posedge clk_i) disable iff (rst_i)
        false_car_ev_i |=> s_q.fcar ##1 s_q.status[11];
    endproperty
    a_fcar_set: assert property (p_fcar_set)
        else $error("false carrier latch not set");

    property p_ipend_set;
        @(posedge clk_i) disable iff (rst_i)
        int_pending_i |=> s_q.ipend ##1 s_q.status[7];
    endproperty
    a_ipend_set: assert property (p_ipend_set)
        else $error("pending bit not set");

    property p_pol_mirror;
        @(posedge clk_i) disable iff (rst_i)
        ##1 s_q.status[12] == $past(polarity_inv_i);
    endproperty
    a_pol_mirror: assert property (p_pol_mirror)
        else $error("polarity bit not mirrored");

    // straps only count once caught; before that the reset value stands
    property p_strap_common_pinout_mode;
        @(posedge clk_i) disable iff (rst_i)
        !an_enable_i && !s_q.strap_ext && s_q.strap_taken
            |=> s_q.status[2] == $past(s_q.strap_dup)
                && s_q.status[1] == $past(s_q.strap_spd);
    endproperty
    a_strap_common_pinout_mode: assert property (p_strap_common_pinout_mode)
        else $error("strapped duplex or speed not shown");

    // no disable here: the check is about the reset itself
    property p_reset_value;
        @(posedge clk_i)
        rst_i |=> s_q.status == pss_pkg::STATUS_RST && !ack_o && !irq_o;
    endproperty
    a_reset_value: assert property (p_reset_value)
        else $error("summary word reset value wrong");

    property p_ack_next;
        @(posedge clk_i) disable iff (rst_i)
        cyc_i && stb_i && !ack_o |=> ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("request not answered next cycle");

    c_status_read: cover property (@(posedge clk_i) disable iff (rst_i)
        req && !we_i && idx == pss_pkg::IDX_STATUS ##1 ack_o);
    c_irq: cover property (@(posedge clk_i) disable iff (rst_i)
        $rose(irq_o));
    c_set_clear: cover property (@(posedge clk_i) disable iff (rst_i)
        rx_err_ev_i && rx_err_cnt_rd_i);
    c_strap_caught: cover property (@(posedge clk_i) disable iff (rst_i)
        $rose(s_q.strap_taken));
    c_latch_clear: cover property (@(posedge clk_i) disable iff (rst_i)
        s_q.rxerr ##1 !s_q.rxerr);

endmodule // pss_status_regs

// ==== test_phy_status_summary_register.sv ====
`timescale 1ns/1ps
module test_phy_status_summary_register;
    ////////////////////////////////////////////////////////////////////////
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        irq_o;
    logic [3:0]  ev    = 4'h0;   // rx err, false carrier, int pending, fault
    logic [3:0]  clr   = 4'h0;   // matching clear pulses
    logic [8:0]  mir   = 9'h000; // mirrored level sources
    logic        an_en = 1'b1;
    logic        an_fd = 1'b0;
    logic        an_s10 = 1'b1;
    logic        st_d  = 1'b1;
    logic        st_s  = 1'b0;
    logic        ext   = 1'b0;
    logic [32:0] q[$];           // {compare enable, expected read data}
    int          n_fail = 0;
    int          num_checks = 0;
    int          cycles = 0;
    logic [15:0] base;
    int          lat_bit[4] = '{13, 11, 7, 6};

    // clock at 100 MHz
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    pss_status_regs pss_status_regs_inst (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o),
        .pair_swap_i(mir[0]), .rx_err_ev_i(ev[0]), .rx_err_cnt_rd_i(clr[0]),
        .polarity_inv_i(mir[1]), .false_car_ev_i(ev[1]),
        .false_car_cnt_rd_i(clr[1]), .signal_detect_i(mir[2]),
        .descr_lock_i(mir[3]), .page_rcvd_i(mir[4]),
        .int_pending_i(ev[2]), .int_status_rd_i(clr[2]),
        .remote_fault_ev_i(ev[3]), .base_status_rd_i(clr[3]),
        .jabber_i(mir[5]), .an_enable_i(an_en), .an_complete_i(mir[6]),
        .an_full_duplex_i(an_fd), .an_speed_10_i(an_s10),
        .mii_loopback_i(mir[7]), .link_i(mir[8]),
        .strap_duplex_i(st_d), .strap_speed_10_i(st_s), .ext_mode_i(ext),
        .irq_o(irq_o)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // one classic cycle; request held until the edge that sees ack
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] exp,
                      input logic c);
        q.push_back({c, exp});
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= 4'hF;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic do_reset();
        rst_i <= 1'b1;
        tick(3);
        rst_i <= 1'b0;
        tick(1);
    endtask

    // expected word from the mirrored levels with negotiation on
    function automatic logic [15:0] mir_word();
        return {1'b0, mir[0], 1'b0, mir[1], 1'b0, mir[2], mir[3], mir[4],
                2'b00, mir[5], mir[6], mir[7], an_fd, an_s10, mir[8]};
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // monitor: every ack retires the oldest note; reads data in ack cycle
    always @(posedge clk_i) begin
        logic [32:0] e;
        if (ack_o === 1'b1 && q.size() > 0) begin
            e = q.pop_front();
            if (e[32]) chk(dat_o, e[31:0]);
        end
    end

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        r = $urandom(32'hA34B);
        do_reset();
        wb(0, 8'h40, 0, 32'h0002, 1);
        wb(0, 8'h44, 0, 32'h0108, 1);
        wb(1, 8'h44, 32'hFFFF, 0, 0);
        wb(0, 8'h44, 0, 32'hFB1F, 1);
        wb(0, 8'h7C, 0, 32'h0000, 1);
        $display("reset values done");
        // random mirrors, each word read twice: reads must not clear them
        repeat (8) begin
            r = $urandom();
            mir <= r[8:0];
            an_fd <= r[9];
            an_s10 <= r[10];
            tick(4);
            wb(0, 8'h40, 0, {16'h0, mir_word()}, 1);
            wb(0, 8'h40, 0, {16'h0, mir_word()}, 1);
        end
        // write attempt on the summary word is ignored
        wb(1, 8'h40, 32'hFFFF, 0, 0);
        wb(0, 8'h40, 0, {16'h0, mir_word()}, 1);
        $display("mirror test done");
        // latches: set by event, kept over summary read, cleared elsewhere
        mir <= 9'h000;
        an_s10 <= 1'b1;
        an_fd <= 1'b0;
        tick(3);
        base = 16'h0002;
        for (int i = 0; i < 4; i++) begin
            ev[i] <= 1'b1;
            @(posedge clk_i);
            ev[i] <= 1'b0;
            tick(3);
            wb(0, 8'h40, 0, base | (16'h1 << lat_bit[i]), 1);
            wb(0, 8'h40, 0, base | (16'h1 << lat_bit[i]), 1);
            clr[i] <= 1'b1;
            @(posedge clk_i);
            clr[i] <= 1'b0;
            tick(3);
            wb(0, 8'h40, 0, base, 1);
        end
        $display("latch test done");
        // interrupt: clear status, unmask bit 0, raise, read-clear, mask
        wb(0, 8'h60, 0, 0, 0);
        wb(1, 8'h64, 32'h1, 0, 0);
        wb(0, 8'h64, 0, 32'h1, 1);
        ev[0] <= 1'b1;
        @(posedge clk_i);
        ev[0] <= 1'b0;
        tick(3);
        chk(irq_o, 1'b1);
        wb(0, 8'h60, 0, 32'h1, 1);
        tick(2);
        chk(irq_o, 1'b0);
        wb(1, 8'h64, 32'h0, 0, 0);
        ev[0] <= 1'b1;
        @(posedge clk_i);
        ev[0] <= 1'b0;
        tick(3);
        chk(irq_o, 1'b0);
        wb(0, 8'h60, 0, 32'h1, 1);
        clr[0] <= 1'b1;
        @(posedge clk_i);
        clr[0] <= 1'b0;
        $display("interrupt test done");
        // negotiation off: common pinout takes the straps
        an_en <= 1'b0;
        tick(3);
        wb(0, 8'h40, 0, 32'h0004, 1);
        // second reset in extended mode: both bits read one
        ext <= 1'b1;
        st_d <= 1'b0;
        st_s <= 1'b0;
        do_reset();
        tick(6);
        wb(0, 8'h40, 0, 32'h0006, 1);
        $display("strap test done");
        tick(2);
        tally_and_finish();
    end
endmodule // test_phy_status_summary_register
